// ---- pkg/pms_params.svh ----
// timing and encoding constants for the powered-device mode sequencer
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH
`define PMS_CLK_HZ 125000000
`define PMS_TICK_US 100
// one 100 us tick from the 125 MHz clock
`define PMS_TICK_CYC ((`PMS_CLK_HZ / 1000000) * `PMS_TICK_US)
// times in ms and us, expressed in 100 us ticks
`define PMS_AC_MIN_MS 76
`define PMS_AC_MAX_MS 87
`define PMS_LONG_EVT_MS 82
`define PMS_LONG_EVT_TICKS (`PMS_LONG_EVT_MS * 10)
`define PMS_LIM_EN_US 1200
`define PMS_LIM_EN_TICKS (`PMS_LIM_EN_US / `PMS_TICK_US)
`define PMS_PG_DELAY_TICKS 10
// indicator: 250 Hz = 4 ms period = 40 ticks, 25% high = 10 ticks
`define PMS_IND_PERIOD_TICKS 40
`define PMS_IND_HIGH_TICKS 10
// keep-alive duty codes
`define PMS_DUTY_ABOVE25 2'h0
`define PMS_DUTY_25 2'h1
`define PMS_DUTY_10 2'h2
`define PMS_DUTY_5 2'h3
// config input settings
`define PMS_CFG_FLOAT 2'h0
`define PMS_CFG_332K 2'h1
`define PMS_CFG_121K 2'h2
`define PMS_CFG_SHORT 2'h3
`endif

// ---- pkg/pms_pkg.sv ----
// types for the powered-device mode sequencer
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_OFF,
    PMS_STARTUP,
    PMS_POWER,
    PMS_SLEEP,
    PMS_ULP_SLEEP,
    PMS_THERMAL,
    PMS_ADAPTER
  } pms_state_t;
  // analog comparator results
  typedef struct packed {
    logic vin_above_mark;
    logic vin_above_on;
    logic in_class_range;
    logic class_event;
    logic switch_full_on;
    logic temp_above_150;
    logic temp_below_120;
    logic adapter_above_9v;
    logic at_power_limit;
    logic at_current_limit;
    logic at_overload_2a4;
  } pms_analog_t;
  // decoded outputs toward the analog core
  typedef struct packed {
    logic switch_on;
    logic class_current_on;
    logic class0_drop;
    logic keepalive_cmp_on;
    logic event_sink_on;
    logic indicator_on;
    logic [1:0] keepalive_duty;
    logic autoclass_active;
  } pms_ctrl_t;
endpackage : pms_pkg

// ---- rtl/pms_sequencer.sv ----
// mode and sequencing logic of a poe powered device
// How it works
// - falling edge on wake input leaves sleep or ultra-low-power sleep
// - power good held low in either sleep mode, released on wake
// - indicator pulses at 250 Hz, 25% duty in both sleep modes
// - power good low for delay after power-up and until switch fully on
// - power good low in overtemperature, high after recovery
// - autoclass drops to class-0 between 76 and 87 ms into first event
// - decode four config settings into keep-alive duty and autoclass permission
// - floating or 332k setting never drops classification current
// - 82 ms timer starts at first classification event, marks it long
// - short first event: no autoclass, keep-alive duty 25%
// - long event with permission: cut current at 82 ms, duty per setting
// - above 150 C switch, indicator and event sink turn off
// - below 120 C pass through startup before power mode
// - adapter detection enabled only after input passed mark threshold
// - adapter present above 9 V takes priority over cable power
// - adapter: switch off, event sink on, class current off, keep-alive cmp off
// - class from class resistor code and event count sets limit reference
// - limit input floating gives power-limit, grounded gives current-limit
// - limiting off during ramp, enabled 1.2 ms after switch fully on
// - power-limit mode sinks from limit output when power at limit
// - current-limit mode sinks when current reaches class threshold
// - floating limit sense disables limiting; 2.4 A overload takes over
// - limit mode changes only while limiting loop is inactive
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"

module pms_sequencer #(
  parameter int TICK_CYC = `PMS_TICK_CYC,
  parameter int PG_DELAY_TICKS = `PMS_PG_DELAY_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic wake_request_n_i,
  input wire logic sleep_request_n_i,
  input wire logic ultra_low_power_select_n_i,
  input wire logic [1:0] autoclass_config_input_i,
  input wire logic limit_level_grounded_i,
  input wire logic limit_sense_floating_i,
  input wire logic [1:0] class_program_resistor_i,
  input wire pms_pkg::pms_analog_t analog_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic power_good_out_o,
  output logic power_good_out_oe_o,
  output logic limit_sink_output_o,
  output logic overload_limit_o,
  output pms_pkg::pms_ctrl_t ctrl_o,
  output logic [3:0] power_class_o
);
  import pms_pkg::*;

  localparam int NSYNC = 9;
  localparam int NA = $bits(pms_analog_t);

  // two-stage synchronisers; first stage read only by the second
  // pins reset to their idle-high level so the edge detectors see no
  // false falling edge in the first cycles after reset
  logic [NSYNC-1:0] pin_s1_q;
  logic [NSYNC-1:0] pin_s2_q;
  logic [NA-1:0] ana_s1_q;
  logic [NA-1:0] ana_s2_q;
  pms_analog_t ana;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= {NSYNC{1'b1}};
      pin_s2_q <= {NSYNC{1'b1}};
      ana_s1_q <= '0;
      ana_s2_q <= '0;
    end else if (clk_en_i) begin
      pin_s1_q <= {wake_request_n_i, sleep_request_n_i, ultra_low_power_select_n_i,
                   autoclass_config_input_i, limit_level_grounded_i,
                   limit_sense_floating_i, class_program_resistor_i};
      pin_s2_q <= pin_s1_q;
      ana_s1_q <= analog_i;
      ana_s2_q <= ana_s1_q;
    end
  end
  assign ana = pms_analog_t'(ana_s2_q);
  logic wake_n, sleep_n, ulp_n, lim_gnd, sense_float;
  logic [1:0] cfg, cls_res;
  assign {wake_n, sleep_n, ulp_n, cfg, lim_gnd, sense_float, cls_res} = pin_s2_q;

  // edge detection on synchronised wake and sleep
  logic wake_d1_q, sleep_d1_q, class_d1_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_d1_q <= 1'b1;
      sleep_d1_q <= 1'b1;
      class_d1_q <= 1'b0;
    end else if (clk_en_i) begin
      wake_d1_q <= wake_n;
      sleep_d1_q <= sleep_n;
      class_d1_q <= ana.class_event;
    end
  end
  logic wake_fall, sleep_fall, class_rise;
  assign wake_fall = wake_d1_q & ~wake_n;
  assign sleep_fall = sleep_d1_q & ~sleep_n;
  assign class_rise = ~class_d1_q & ana.class_event;

  // 100 us tick prescaler; timers derive from it
  // one shared tick keeps every ms timer on one time base; the price is
  // up to one tick of jitter where a timer starts, well inside the window
  logic [15:0] pre_q;
  logic tick;
  assign tick = (pre_q == 16'(TICK_CYC - 1));
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= 16'h0000;
    end else if (clk_en_i) begin
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  // config decode used by duty selection and autoclass permission
  function automatic logic cfg_allows_ac(input logic [1:0] c);
    return (c == `PMS_CFG_121K) || (c == `PMS_CFG_SHORT);
  endfunction : cfg_allows_ac
  function automatic logic [1:0] cfg_duty(input logic [1:0] c);
    case (c)
      `PMS_CFG_FLOAT: cfg_duty = `PMS_DUTY_ABOVE25;
      `PMS_CFG_332K: cfg_duty = `PMS_DUTY_25;
      `PMS_CFG_121K: cfg_duty = `PMS_DUTY_10;
      default: cfg_duty = `PMS_DUTY_5;
    endcase
  endfunction : cfg_duty

  // main mode state machine
  pms_state_t state_q;
  logic adapter_en_q;
  logic [7:0] pg_cnt_q;
  logic pg_ok;
  assign pg_ok = (pg_cnt_q >= 8'(PG_DELAY_TICKS)) && ana.switch_full_on;
  logic adapter_det;
  assign adapter_det = adapter_en_q & ana.adapter_above_9v;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= PMS_OFF;
    end else if (clk_en_i) begin
      if (ana.temp_above_150 && state_q != PMS_OFF) begin
        state_q <= PMS_THERMAL;
      end else if (adapter_det) begin
        state_q <= PMS_ADAPTER;
      end else begin
        case (state_q)
          PMS_OFF: if (ana.vin_above_on) state_q <= PMS_STARTUP;
          PMS_STARTUP: if (pg_ok) state_q <= PMS_POWER;
          PMS_POWER: if (sleep_fall) begin
            state_q <= ulp_n ? PMS_SLEEP : PMS_ULP_SLEEP;
          end
          PMS_SLEEP, PMS_ULP_SLEEP: if (wake_fall) state_q <= PMS_POWER;
          PMS_THERMAL: if (ana.temp_below_120) state_q <= PMS_STARTUP;
          PMS_ADAPTER: state_q <= PMS_ADAPTER;
          default: state_q <= PMS_OFF;
        endcase
      end
    end
  end

  // adapter detection armed once input has passed the mark threshold
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adapter_en_q <= 1'b0;
    end else if (clk_en_i && ana.vin_above_mark) begin
      adapter_en_q <= 1'b1;
    end
  end

  // power-good delay counter restarts on each startup entry
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_cnt_q <= 8'h00;
    end else if (clk_en_i) begin
      if (state_q != PMS_STARTUP) begin
        pg_cnt_q <= 8'h00;
      end else if (tick && !pg_ok && pg_cnt_q != 8'hFF) begin
        pg_cnt_q <= pg_cnt_q + 8'h01;
      end
    end
  end

  // power good: open drain, low drive except in power mode
  // the pin level is always low; only the enable says whether it is pulled
  logic pg_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_q <= 1'b0;
    end else if (clk_en_i) begin
      pg_q <= (state_q == PMS_POWER);
    end
  end
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_o = ~pg_q;

  // indicator pulse generator, 4 ms period, 1 ms high
  logic [5:0] ind_cnt_q;
  logic ind_q;
  logic in_sleep;
  assign in_sleep = (state_q == PMS_SLEEP) || (state_q == PMS_ULP_SLEEP);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ind_cnt_q <= 6'h00;
      ind_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!in_sleep) begin
        ind_cnt_q <= 6'h00;
        ind_q <= 1'b0;
      end else if (tick) begin
        ind_cnt_q <= (ind_cnt_q == 6'(`PMS_IND_PERIOD_TICKS - 1)) ? 6'h00 : ind_cnt_q + 6'h01;
        ind_q <= (ind_cnt_q < 6'(`PMS_IND_HIGH_TICKS));
      end
    end
  end

  // first classification event timer and autoclass decision
  logic [9:0] cls_cnt_q;
  logic first_seen_q, long_q, ac_q, drop_q;
  logic [2:0] evt_cnt_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cls_cnt_q <= 10'h000;
      first_seen_q <= 1'b0;
      long_q <= 1'b0;
      ac_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (clk_en_i) begin
      if (class_rise && !first_seen_q) begin
        first_seen_q <= 1'b1;
        cls_cnt_q <= 10'h000;
      end else if (first_seen_q && ana.class_event && !long_q && evt_cnt_q == 3'h1) begin
        if (tick) begin
          cls_cnt_q <= cls_cnt_q + 10'h001;
        end
        if (cls_cnt_q == 10'(`PMS_LONG_EVT_TICKS)) begin
          long_q <= 1'b1;
          ac_q <= cfg_allows_ac(cfg);
          drop_q <= cfg_allows_ac(cfg);
        end
      end
      if (class_d1_q && !ana.class_event) begin
        drop_q <= 1'b0;
      end
    end
  end

  // count classification events for class derivation
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_cnt_q <= 3'h0;
    end else if (clk_en_i && class_rise && evt_cnt_q != 3'h7) begin
      evt_cnt_q <= evt_cnt_q + 3'h1;
    end
  end

  // class: events 1->3, 2/3->4, 4->5/6, 5->7/8 by resistor code bit
  logic [3:0] cls_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cls_q <= 4'h0;
    end else if (clk_en_i && state_q == PMS_STARTUP) begin
      case (evt_cnt_q)
        3'h0, 3'h1: cls_q <= 4'h3;
        3'h2, 3'h3: cls_q <= 4'h4;
        3'h4: cls_q <= cls_res[0] ? 4'h5 : 4'h6;
        default: cls_q <= cls_res[0] ? 4'h7 : 4'h8;
      endcase
    end
  end
  assign power_class_o = cls_q;

  // limiting enable 1.2 ms after switch fully on
  logic [3:0] lim_cnt_q;
  logic lim_en_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lim_cnt_q <= 4'h0;
      lim_en_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!ana.switch_full_on || state_q == PMS_STARTUP || state_q == PMS_OFF) begin
        lim_cnt_q <= 4'h0;
        lim_en_q <= 1'b0;
      end else if (tick && !lim_en_q) begin
        lim_cnt_q <= lim_cnt_q + 4'h1;
        lim_en_q <= (lim_cnt_q == 4'(`PMS_LIM_EN_TICKS - 1));
      end
    end
  end

  // limit mode and sink drive; mode only follows input while loop idle
  // the registered sink marks the loop as busy, so a mode request that
  // lands while sinking is held off until the sink has released
  logic cur_mode_q, sink_q, ovl_q;
  logic sink_d;
  assign sink_d = lim_en_q && !sense_float &&
                  (cur_mode_q ? ana.at_current_limit : ana.at_power_limit);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_mode_q <= 1'b0;
      sink_q <= 1'b0;
      ovl_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!sink_q) begin
        cur_mode_q <= lim_gnd;
      end
      sink_q <= sink_d;
      ovl_q <= ana.at_overload_2a4 && ana.switch_full_on;
    end
  end
  assign limit_sink_output_o = sink_q;
  assign overload_limit_o = ovl_q;

  // controls toward the analog core
  pms_ctrl_t ctrl_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= '0;
    end else if (clk_en_i) begin
      ctrl_q.switch_on <= (state_q == PMS_STARTUP) || (state_q == PMS_POWER) || in_sleep;
      ctrl_q.class_current_on <= ana.in_class_range && !drop_q &&
                                 state_q != PMS_ADAPTER;
      ctrl_q.class0_drop <= drop_q;
      ctrl_q.keepalive_cmp_on <= ana.switch_full_on && state_q != PMS_ADAPTER &&
                                 state_q != PMS_THERMAL;
      ctrl_q.event_sink_on <= (state_q == PMS_ADAPTER) || (state_q == PMS_POWER);
      ctrl_q.indicator_on <= ind_q && state_q != PMS_THERMAL;
      // a long first event applies the configured duty even without autoclass,
      // a short one always falls back to the 25% pattern
      ctrl_q.keepalive_duty <= long_q ? cfg_duty(cfg) : `PMS_DUTY_25;
      ctrl_q.autoclass_active <= ac_q;
    end
  end
  assign ctrl_o = ctrl_q;

  // wishbone slave: 0x00 status (read), 0x04 scratch (rw), else reads zero
  logic [31:0] dat_q;
  logic ack_q;
  logic [7:0] scratch_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      scratch_q <= 8'h00;
    end else if (clk_en_i) begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        if (wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]) begin
          scratch_q <= wb_dat_i[7:0];
        end
        case (wb_adr_i)
          8'h00: dat_q <= {16'h0000, cls_q, 1'(ac_q), 1'(long_q), 1'(cur_mode_q),
                           1'(lim_en_q), 1'(sink_q), 1'(pg_q), 3'(state_q), 3'h0};
          8'h04: dat_q <= {24'h000000, scratch_q};
          default: dat_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
endmodule : pms_sequencer
`default_nettype wire

// ---- sim/pms_pse_model.sv ----
// cable power source model: one classification event, then full voltage, plus switch ramp
`timescale 1ns/10ps
`default_nettype none
module pms_pse_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [15:0] evt_cyc_i,
  input wire logic switch_on_i,
  output logic vin_above_mark_o,
  output logic vin_above_on_o,
  output logic in_class_range_o,
  output logic class_event_o,
  output logic switch_full_on_o
);
  logic [15:0] evt_q;
  logic [7:0] ramp_q;
  // event length is chosen by the bench so long and short first events both occur
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_q <= 16'h0;
      vin_above_mark_o <= 1'b0;
      vin_above_on_o <= 1'b0;
      in_class_range_o <= 1'b0;
      class_event_o <= 1'b0;
    end else if (go_i) begin
      evt_q <= evt_cyc_i;
      vin_above_mark_o <= 1'b1;
      in_class_range_o <= 1'b1;
      class_event_o <= 1'b1;
    end else if (class_event_o && evt_q == 16'h0) begin
      class_event_o <= 1'b0;
      in_class_range_o <= 1'b0;
      vin_above_on_o <= 1'b1;
    end else if (class_event_o) begin
      evt_q <= evt_q - 16'h1;
    end
  end
  // switch needs 200 cycles to enhance and collapses at once when turned off
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) ramp_q <= 8'h0;
    else if (!switch_on_i) ramp_q <= 8'h0;
    else if (ramp_q != 8'hC8) ramp_q <= ramp_q + 8'h1;
  end
  assign switch_full_on_o = (ramp_q == 8'hC8);
endmodule : pms_pse_model
`default_nettype wire

// ---- sim/pms_sequencer_bench.sv ----
// self-checking bench for the powered-device mode sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"
module pms_sequencer_bench;
  import pms_pkg::*;
  localparam logic [1:0] DUTY [4] = '{`PMS_DUTY_ABOVE25, `PMS_DUTY_25, `PMS_DUTY_10, `PMS_DUTY_5};
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, wake_n = 1'b1, sleep_n = 1'b1, ulp_n = 1'b1;
  logic lim_gnd = 1'b0, flt = 1'b0, go = 1'b0, we = 1'b0, cyc = 1'b0;
  logic ack, pg, pg_oe, sink, ovl, vm, von, vcr, vce, vsw;
  logic [1:0] cfg = 2'h0;
  logic [15:0] evt_len = 16'h0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, st;
  logic [3:0] cls;
  pms_analog_t ana, bana = '0;
  pms_ctrl_t ctrl;
  int num_errors = 0, n_tests = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  // cable-side comparators come from the source model, the rest from the bench
  always_comb begin
    ana = bana;
    ana.vin_above_mark = vm;
    ana.vin_above_on = von;
    ana.in_class_range = vcr;
    ana.class_event = vce;
    ana.switch_full_on = vsw;
  end
  pms_sequencer #(.TICK_CYC(10), .PG_DELAY_TICKS(1)) dut_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .wake_request_n_i(wake_n),
    .sleep_request_n_i(sleep_n), .ultra_low_power_select_n_i(ulp_n),
    .autoclass_config_input_i(cfg), .limit_level_grounded_i(lim_gnd),
    .limit_sense_floating_i(flt), .class_program_resistor_i(2'h0), .analog_i(ana),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .power_good_out_o(pg),
    .power_good_out_oe_o(pg_oe), .limit_sink_output_o(sink), .overload_limit_o(ovl),
    .ctrl_o(ctrl), .power_class_o(cls));
  pms_pse_model pse_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .go_i(go), .evt_cyc_i(evt_len),
    .switch_on_i(ctrl.switch_on), .vin_above_mark_o(vm), .vin_above_on_o(von),
    .in_class_range_o(vcr), .class_event_o(vce), .switch_full_on_o(vsw));
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick
  // one classic cycle; the idle edge after it keeps cyc low between requests
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    st = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge sys_clk_i);
  endtask : bus
  task automatic wait_pg(input logic lvl);
    for (int k = 0; k < 12000 && pg_oe !== lvl; k++) @(posedge sys_clk_i);
    if (pg_oe !== lvl) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_pg
  task automatic restart(input logic [1:0] c, input logic [15:0] len);
    nrst_i <= 1'b0;
    cfg <= c;
    evt_len <= len;
    bana <= '0;
    tick(2);
    nrst_i <= 1'b1;
    tick(1);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
  endtask : restart
  task automatic state_is(input pms_state_t s);
    bus(1'b0, 8'h00, 32'h0);
    check("state", 32'(st[5:3]), 32'(s));
  endtask : state_is
  initial begin
    // long first event under every configuration setting
    for (int c = 0; c < 4; c++) begin
      restart(2'(c), 16'h2328);
      tick(7550);
      check("early drop", 32'(ctrl.class0_drop), 32'h0);
      tick(1200);
      check("drop", 32'(ctrl.class0_drop), 32'(c >= 2));
      wait_pg(1'b0);
      state_is(PMS_POWER);
      check("long", 32'(st[10]), 32'h1);
      check("autoclass", 32'(st[11]), 32'(c >= 2));
      check("autoclass out", 32'(ctrl.autoclass_active), 32'(c >= 2));
      check("duty", 32'(ctrl.keepalive_duty), 32'(DUTY[c]));
    end
    restart(2'h3, 16'h0BB8);
    wait_pg(1'b0);
    state_is(PMS_POWER);
    check("short", 32'(st[11:10]), 32'h0);
    check("duty short", 32'(ctrl.keepalive_duty), 32'(`PMS_DUTY_25));
    check("class", 32'(cls), 32'h3);
    check("class field", 32'(st[15:12]), 32'h3);
    bus(1'b1, 8'h04, 32'h000000A5);
    bus(1'b0, 8'h04, 32'h0);
    check("scratch", st, 32'h000000A5);
    bus(1'b0, 8'h08, 32'h0);
    check("unmapped", st, 32'h0);
    // limiting: power mode, deferred mode change, current mode, overload, floating sense
    tick(200);
    bana.at_power_limit <= 1'b1;
    tick(8);
    check("sink power", 32'(sink), 32'h1);
    // mode request arrives while the loop is sinking, so it must wait
    lim_gnd <= 1'b1;
    tick(8);
    state_is(PMS_POWER);
    check("limit on", 32'(st[9:8]), 32'h1);
    bana.at_power_limit <= 1'b0;
    tick(8);
    state_is(PMS_POWER);
    check("current mode", 32'(st[9]), 32'h1);
    bana.at_current_limit <= 1'b1;
    bana.at_overload_2a4 <= 1'b1;
    tick(8);
    check("sink current", 32'(sink), 32'h1);
    check("overload", 32'(ovl), 32'h1);
    flt <= 1'b1;
    tick(8);
    check("sink floating", 32'(sink), 32'h0);
    bana <= '0;
    flt <= 1'b0;
    lim_gnd <= 1'b0;
    // both sleep kinds, each left by a wake edge
    for (int i = 0; i < 2; i++) begin
      ulp_n <= 1'(i);
      tick(4);
      sleep_n <= 1'b0;
      tick(8);
      state_is(i ? PMS_SLEEP : PMS_ULP_SLEEP);
      check("pg sleep", 32'(pg_oe), 32'h1);
      check("pg level", 32'(pg), 32'h0);
      sleep_n <= 1'b1;
      tick(900);
      wake_n <= 1'b0;
      tick(12);
      check("pg wake", 32'(pg_oe), 32'h0);
      state_is(PMS_POWER);
      wake_n <= 1'b1;
      tick(900);
    end
    bana.temp_above_150 <= 1'b1;
    tick(8);
    check("pg hot", 32'(pg_oe), 32'h1);
    check("switch hot", 32'(ctrl.switch_on), 32'h0);
    bana.temp_above_150 <= 1'b0;
    bana.temp_below_120 <= 1'b1;
    tick(8);
    state_is(PMS_STARTUP);
    wait_pg(1'b0);
    state_is(PMS_POWER);
    // adapter ignored until the mark threshold, then takes over
    nrst_i <= 1'b0;
    bana <= '0;
    tick(2);
    bana.adapter_above_9v <= 1'b1;
    nrst_i <= 1'b1;
    tick(20);
    state_is(PMS_OFF);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(20);
    state_is(PMS_ADAPTER);
    check("adapter sink", 32'(ctrl.event_sink_on), 32'h1);
    check("adapter class", 32'(ctrl.class_current_on), 32'h0);
    tally_and_finish();
  end
endmodule : pms_sequencer_bench
`default_nettype wire

// ---- sim/pms_sequencer_sva.sv ----
// port assertions for the powered-device mode sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"
module pms_sequencer_sva #(
  parameter int TICK_CYC = `PMS_TICK_CYC,
  parameter int PG_DELAY_TICKS = `PMS_PG_DELAY_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic wake_request_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire pms_pkg::pms_analog_t analog_i,
  input wire logic power_good_out_oe_o,
  input wire logic limit_sink_output_o,
  input wire logic overload_limit_o,
  input wire logic limit_sense_floating_i,
  input wire pms_pkg::pms_ctrl_t ctrl_o
);
  import pms_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  localparam int HI_CYC = `PMS_IND_HIGH_TICKS * TICK_CYC;
  localparam int PER_CYC = `PMS_IND_PERIOD_TICKS * TICK_CYC;
  logic [31:0] hi_q;
  logic [31:0] gap_q;
  logic ind_q;
  // pulse width and rise spacing; gap starts saturated so a first pulse passes
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_q <= 32'h0;
      gap_q <= 2 * PER_CYC;
      ind_q <= 1'b0;
    end else begin
      hi_q <= ctrl_o.indicator_on ? hi_q + 32'h1 : 32'h0;
      ind_q <= ctrl_o.indicator_on;
      if (ctrl_o.indicator_on && !ind_q) gap_q <= 32'h1;
      else if (gap_q < 2 * PER_CYC) gap_q <= gap_q + 32'h1;
    end
  end
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_answer_a: assert property (wb_req_s |=> ack_pulse_s)
    else $error("bus answer is not a one-cycle ack");
  ind_width_a: assert property ($fell(ctrl_o.indicator_on) && wake_request_n_i |-> hi_q == HI_CYC)
    else $error("indicator pulse width wrong");
  ind_period_a: assert property (ctrl_o.indicator_on && !ind_q |-> gap_q == PER_CYC || gap_q >= 2 * PER_CYC)
    else $error("indicator period wrong");
  pg_sleep_a: assert property (ctrl_o.indicator_on && $past(ctrl_o.indicator_on) |-> power_good_out_oe_o)
    else $error("power good released while sleeping");
  pg_ramp_a: assert property ($fell(power_good_out_oe_o) |-> $past(analog_i.switch_full_on, 3))
    else $error("power good released before switch fully on");
  thermal_off_a: assert property (analog_i.temp_above_150 [*6] |-> power_good_out_oe_o && !ctrl_o.switch_on && !ctrl_o.indicator_on && !ctrl_o.event_sink_on)
    else $error("outputs not off in overtemperature");
  adapter_off_a: assert property ((analog_i.adapter_above_9v && analog_i.vin_above_mark && !analog_i.temp_above_150) [*6] |-> !ctrl_o.switch_on && !ctrl_o.class_current_on && !ctrl_o.keepalive_cmp_on)
    else $error("adapter did not take over");
  lim_ramp_a: assert property (!analog_i.switch_full_on [*6] |-> !limit_sink_output_o)
    else $error("limit sink active during ramp");
  lim_float_a: assert property (limit_sense_floating_i [*6] |-> !limit_sink_output_o)
    else $error("limit sink active with sense floating");
  overload_a: assert property (!analog_i.at_overload_2a4 [*6] |-> !overload_limit_o)
    else $error("overload limit without overload");
endmodule : pms_sequencer_sva
bind pms_sequencer pms_sequencer_sva #(.TICK_CYC(TICK_CYC), .PG_DELAY_TICKS(PG_DELAY_TICKS)) sva_u (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
  .wake_request_n_i(wake_request_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .analog_i(analog_i), .power_good_out_oe_o(power_good_out_oe_o),
  .limit_sink_output_o(limit_sink_output_o), .overload_limit_o(overload_limit_o),
  .limit_sense_floating_i(limit_sense_floating_i), .ctrl_o(ctrl_o));
`default_nettype wire
